// ===== common/uhi_defs.vh
// Purpose: constants for the usb hub interrupt unit
// Assumes: 8-bit register port, byte-wide registers
// Notes: offsets without a printed value are chosen locally
`ifndef UHI_DEFS_VH
`define UHI_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UHI_ADDR_W 13
`define UHI_OFS_PSF 13'h003F
`define UHI_OFS_UES 13'h1FF7
`define UHI_OFS_SRE 13'h1FF9
`define UHI_OFS_UEM 13'h1FF0
`define UHI_OFS_UEA 13'h1FF1
`define UHI_OFS_UEE 13'h1FF2
`define UHI_OFS_SRS 13'h1FF3
`define UHI_OFS_SRM 13'h1FF4

// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define UHI_BIT_SOF 7
`define UHI_BIT_EOF2 6
`define UHI_BIT_FEP3 4
`define UHI_BIT_HEP0 3
`define UHI_BIT_FEP2 2
`define UHI_BIT_FEP1 1
`define UHI_BIT_FEP0 0
`define UHI_UE_VALID 8'hDF
`define UHI_SR_VALID 8'h0F
`define UHI_BIT_BUSRST 3
`define UHI_BIT_RWUP 2
`define UHI_BIT_RSM 1
`define UHI_BIT_GSUSP 0
`define UHI_BIT_GIE 7
`define UHI_RESET_BYTE 8'h00
`define UHI_NUM_EP 5

// ------------------------------------------------------------
// endpoint types (two bits per endpoint)
// ------------------------------------------------------------
`define UHI_EPT_CTRL 2'h0
`define UHI_EPT_OUT 2'h1
`define UHI_EPT_IN 2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define UHI_EOF2_LEAD 10
`define UHI_BUSRST_MS 3
`define UHI_CLK_HZ 100000000
`define UHI_BUSRST_CYC ((`UHI_BUSRST_MS * `UHI_CLK_HZ) / 1000)

`endif

// ===== src/uhi_ep_event.v
// Purpose: per-endpoint event detector for the interrupt unit
// Assumes: endpoint engine flags are synchronous to sys_clk
// Notes: one pulse out per qualifying flag change

`include "uhi_defs.vh"

module uhi_ep_event (
  input wire sys_clk,        // system clock
  input wire rst_b,          // async reset, active low
  input wire clk_en,         // freezes state when low
  input wire [1:0] ep_type,  // endpoint type code
  input wire rx_out,         // received-out flag level
  input wire rx_setup,       // received-setup flag level
  input wire tx_ready,       // transmit-packet-ready level
  input wire tx_done,        // transmit-complete level
  input wire stall_sent,     // stall-sent level
  output wire ev_pulse       // one-cycle endpoint event
);

  reg rx_out_q;
  reg rx_setup_q;
  reg tx_ready_q;
  reg tx_done_q;
  reg stall_q;

  wire is_ctrl = (ep_type == `UHI_EPT_CTRL);
  wire is_out = (ep_type == `UHI_EPT_OUT);
  wire is_in = (ep_type == `UHI_EPT_IN);
  wire rx_out_rise = rx_out & ~rx_out_q;
  wire setup_rise = rx_setup & ~rx_setup_q;
  wire done_rise = tx_done & ~tx_done_q;
  wire ready_fall = ~tx_ready & tx_ready_q;
  wire stall_rise = stall_sent & ~stall_q;

  // ------------------------------------------------------------
  // trigger qualification by endpoint type
  // ------------------------------------------------------------
  assign ev_pulse = (rx_out_rise & (is_ctrl | is_out))
    | (ready_fall & done_rise & (is_ctrl | is_in))
    | (setup_rise & is_ctrl)
    | (done_rise & (is_ctrl | is_in))
    | (stall_rise & (is_ctrl | is_in));

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_out_q <= 1'b0;
      rx_setup_q <= 1'b0;
      tx_ready_q <= 1'b0;
      tx_done_q <= 1'b0;
      stall_q <= 1'b0;
    end else if (clk_en) begin
      rx_out_q <= rx_out;
      rx_setup_q <= rx_setup;
      tx_ready_q <= tx_ready;
      tx_done_q <= tx_done;
      stall_q <= stall_sent;
    end
  end

endmodule // uhi_ep_event

// ===== src/uhi_irq_unit.v
// Purpose: usb hub interrupt collection with status, enable, mask
// Assumes: register port is one-cycle strobes, read data next cycle
// Notes: no bus wait states; unmapped reads return zero
//
// Chosen here: the strobed register port.

`include "uhi_defs.vh"

module uhi_irq_unit #(
  parameter ADDR_W = `UHI_ADDR_W,       // register address width
  parameter NUM_EP = `UHI_NUM_EP,       // endpoint engines
  parameter NUM_PORTS = 3,              // hub downstream ports
  parameter BUSRST_CYC = `UHI_BUSRST_CYC // se0 length for bus reset
) (
  input wire sys_clk,                   // system clock
  input wire rst_b,                     // async reset, active low
  input wire clk_en,                    // freezes state when low
  input wire [ADDR_W-1:0] reg_addr,     // register address
  input wire [7:0] reg_wdata,           // write data
  input wire reg_wr,                    // write strobe
  input wire reg_rd,                    // read strobe
  output reg [7:0] reg_rdata,           // read data, cycle after strobe
  input wire sof_valid,                 // valid start-of-frame decoded
  input wire [15:0] frame_timer,        // hub frame timer count
  input wire [15:0] frame_period,       // frame timer count at next sof
  input wire [2*NUM_EP-1:0] ep_type,    // per endpoint type code
  input wire [NUM_EP-1:0] ep_rx_out,    // received-out levels
  input wire [NUM_EP-1:0] ep_rx_setup,  // received-setup levels
  input wire [NUM_EP-1:0] ep_tx_ready,  // transmit-ready levels
  input wire [NUM_EP-1:0] ep_tx_done,   // transmit-complete levels
  input wire [NUM_EP-1:0] ep_stall,     // stall-sent levels
  input wire se0_line,                  // upstream single-ended zero
  input wire external_interrupt_input_1, // remote wakeup request
  input wire [NUM_PORTS-1:0] port_resume, // resume seen per port
  input wire global_suspend_seen,       // global suspend detected
  input wire irq_taken,                 // core takes interrupt
  input wire return_from_interrupt,     // core executes return
  output reg irq_req,                   // interrupt request to core
  output reg usb_logic_reset,           // reset to usb logic only
  output reg cpu_reset_req              // reset request to processor
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  reg [7:0] processor_status_flags;
  reg [7:0] usb_event_status;
  reg [7:0] usb_event_mask;
  reg [7:0] usb_event_enable;
  reg [3:0] suspend_resume_status;
  reg [3:0] suspend_resume_enable;
  reg [3:0] suspend_resume_mask;
  reg [31:0] se0_cnt;
  reg se0_hit;
  reg ext1_q;
  reg gsusp_q;
  reg [NUM_PORTS-1:0] resume_q;
  reg [7:0] next_rdata;
  reg [7:0] next_ue_status;
  reg [3:0] next_sr_status;
  reg [7:0] ue_set;
  reg [3:0] sr_set;

  wire [NUM_EP-1:0] ep_ev;
  wire hit_psf = (reg_addr == `UHI_OFS_PSF);
  wire hit_ues = (reg_addr == `UHI_OFS_UES);
  wire hit_uem = (reg_addr == `UHI_OFS_UEM);
  wire hit_uea = (reg_addr == `UHI_OFS_UEA);
  wire hit_uee = (reg_addr == `UHI_OFS_UEE);
  wire hit_srs = (reg_addr == `UHI_OFS_SRS);
  wire hit_sre = (reg_addr == `UHI_OFS_SRE);
  wire hit_srm = (reg_addr == `UHI_OFS_SRM);

  // ------------------------------------------------------------
  // endpoint event detectors, endpoint order 0,1,2,hub0,3
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi = gi + 1) begin : g_ep
      uhi_ep_event u_ev (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .ep_type(ep_type[2*gi+1:2*gi]),
        .rx_out(ep_rx_out[gi]),
        .rx_setup(ep_rx_setup[gi]),
        .tx_ready(ep_tx_ready[gi]),
        .tx_done(ep_tx_done[gi]),
        .stall_sent(ep_stall[gi]),
        .ev_pulse(ep_ev[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  wire eof2_hit = (frame_timer + 16'd`UHI_EOF2_LEAD == frame_period);
  wire resume_other = |(port_resume[NUM_PORTS-1:1] & ~resume_q[NUM_PORTS-1:1]);
  wire bus_sep = suspend_resume_enable[`UHI_BIT_BUSRST]
    & suspend_resume_mask[`UHI_BIT_BUSRST];
  wire se0_long = se0_line & (se0_cnt == BUSRST_CYC - 1) & ~se0_hit;

  always @* begin
    ue_set = `UHI_RESET_BYTE;
    ue_set[`UHI_BIT_SOF] = sof_valid;
    ue_set[`UHI_BIT_EOF2] = eof2_hit;
    ue_set[`UHI_BIT_FEP0] = ep_ev[0];
    ue_set[`UHI_BIT_FEP1] = ep_ev[1];
    ue_set[`UHI_BIT_FEP2] = ep_ev[2];
    ue_set[`UHI_BIT_HEP0] = ep_ev[3];
    ue_set[`UHI_BIT_FEP3] = ep_ev[4];
    sr_set = 4'h0;
    sr_set[`UHI_BIT_BUSRST] = se0_long & bus_sep;
    sr_set[`UHI_BIT_RWUP] = external_interrupt_input_1 & ~ext1_q;
    sr_set[`UHI_BIT_RSM] = resume_other;
    sr_set[`UHI_BIT_GSUSP] = global_suspend_seen & ~gsusp_q;
  end

  // ------------------------------------------------------------
  // next status: set wins over clear
  // ------------------------------------------------------------
  always @* begin
    next_ue_status = usb_event_status;
    if (reg_wr && hit_uea) begin
      next_ue_status = usb_event_status & ~reg_wdata;
    end
    next_ue_status = (next_ue_status | ue_set) & `UHI_UE_VALID;
    next_sr_status = suspend_resume_status;
    if (reg_wr && hit_srs) begin
      next_sr_status = suspend_resume_status & reg_wdata[3:0];
    end
    next_sr_status = next_sr_status | sr_set;
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always @* begin
    next_rdata = `UHI_RESET_BYTE;
    case (1'b1)
      hit_psf: next_rdata = processor_status_flags;
      hit_ues: next_rdata = usb_event_status & `UHI_UE_VALID;
      hit_uem: next_rdata = usb_event_mask & `UHI_UE_VALID;
      hit_uee: next_rdata = usb_event_enable & `UHI_UE_VALID;
      hit_srs: next_rdata = {4'h0, suspend_resume_status};
      hit_sre: next_rdata = {4'h0, suspend_resume_enable};
      hit_srm: next_rdata = {4'h0, suspend_resume_mask};
      default: next_rdata = `UHI_RESET_BYTE;
    endcase
  end

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  wire ue_active = |(usb_event_status & usb_event_enable & ~usb_event_mask);
  wire sr_active = |(suspend_resume_status & suspend_resume_enable
    & suspend_resume_mask);
  wire next_irq = processor_status_flags[`UHI_BIT_GIE]
    & (ue_active | sr_active);

  // ------------------------------------------------------------
  // per-register write strobes
  // ------------------------------------------------------------
  wire wr_psf = reg_wr & hit_psf;
  wire wr_uem = reg_wr & hit_uem;
  wire wr_uee = reg_wr & hit_uee;
  wire wr_sre = reg_wr & hit_sre;
  wire wr_srm = reg_wr & hit_srm;
  wire se0_done = se0_line & (se0_hit | se0_long);

  // ------------------------------------------------------------
  // edge history of the level sources
  // ------------------------------------------------------------
  // reset to the idle low level so that leaving reset gives no false edge
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext1_q <= 1'h0;
      gsusp_q <= 1'h0;
      resume_q <= {NUM_PORTS{1'h0}};
    end else if (clk_en) begin
      ext1_q <= external_interrupt_input_1;
      gsusp_q <= global_suspend_seen;
      resume_q <= port_resume;
    end
  end

  // ------------------------------------------------------------
  // event status flags
  // ------------------------------------------------------------
  // set-versus-clear priority is settled in the next-status logic above
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_event_status <= `UHI_RESET_BYTE;
    end else if (clk_en) begin
      usb_event_status <= next_ue_status;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      suspend_resume_status <= 4'h0;
    end else if (clk_en) begin
      suspend_resume_status <= next_sr_status;
    end
  end

  // ------------------------------------------------------------
  // software configuration registers
  // ------------------------------------------------------------
  // bit 5 has no event behind it, so mask and enable keep it at zero
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_event_mask <= `UHI_RESET_BYTE;
    end else if (clk_en && wr_uem) begin
      usb_event_mask <= reg_wdata & `UHI_UE_VALID;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_event_enable <= `UHI_RESET_BYTE;
    end else if (clk_en && wr_uee) begin
      usb_event_enable <= reg_wdata & `UHI_UE_VALID;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      suspend_resume_enable <= 4'h0;
    end else if (clk_en && wr_sre) begin
      suspend_resume_enable <= reg_wdata[3:0];
    end
  end

  // a suspend mask bit of one shows the event: the reverse of the usb mask
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      suspend_resume_mask <= 4'h0;
    end else if (clk_en && wr_srm) begin
      suspend_resume_mask <= reg_wdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // processor status flags and global enable
  // ------------------------------------------------------------
  // only the global enable is touched by hardware; the rest is storage
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      processor_status_flags <= `UHI_RESET_BYTE;
    end else if (clk_en) begin
      // hardware clear on take wins over a firmware write the same cycle
      if (irq_taken) begin
        processor_status_flags <= {1'b0, processor_status_flags[6:0]};
      end else if (return_from_interrupt) begin
        processor_status_flags <= {1'b1, processor_status_flags[6:0]};
      end else if (wr_psf) begin
        processor_status_flags <= reg_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // read data: one cycle after the strobe, zero otherwise
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `UHI_RESET_BYTE;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : `UHI_RESET_BYTE;
    end
  end

  // ------------------------------------------------------------
  // interrupt request to the core
  // ------------------------------------------------------------
  // dropped in the taking cycle so the core never takes one event twice
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'h0;
    end else if (clk_en) begin
      irq_req <= next_irq & ~irq_taken;
    end
  end

  // ------------------------------------------------------------
  // bus reset length counter
  // ------------------------------------------------------------
  // saturates so one long se0 gives one event; 32 bits hold the
  // count at any clock rate this block is likely to meet
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      se0_cnt <= 32'h0;
      se0_hit <= 1'h0;
    end else if (clk_en) begin
      if (!se0_line) begin
        se0_cnt <= 32'h0;
        se0_hit <= 1'h0;
      end else if (se0_cnt != BUSRST_CYC - 1) begin
        se0_cnt <= se0_cnt + 32'h1;
      end else begin
        se0_hit <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------
  // without separation the long se0 also asks for a processor reset
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_logic_reset <= 1'h0;
      cpu_reset_req <= 1'h0;
    end else if (clk_en) begin
      usb_logic_reset <= se0_done;
      cpu_reset_req <= se0_done & ~bus_sep;
    end
  end

endmodule // uhi_irq_unit

// ===== verification/uhi_ep_model.sv
// Purpose: endpoint engine stand-in that raises flag levels
// Assumes: fire() is called from the bench between clock edges
// Notes: each flag returns to its idle level two cycles after it changes
module uhi_ep_model (
  input wire sys_clk, // system clock
  output logic [4:0] ep_rx_out = 5'h00, // received-out levels
  output logic [4:0] ep_rx_setup = 5'h00, // received-setup levels
  output logic [4:0] ep_tx_ready = 5'h1F, // transmit-ready levels
  output logic [4:0] ep_tx_done = 5'h00, // transmit-complete levels
  output logic [4:0] ep_stall = 5'h00 // stall-sent levels
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic fire(input int k, input int i);
    @(posedge sys_clk);
    case (k)
      0: ep_rx_out[i] <= 1'h1;
      1: ep_rx_setup[i] <= 1'h1;
      2: begin
        ep_tx_ready[i] <= 1'h0;
        ep_tx_done[i] <= 1'h1;
      end
      default: ep_stall[i] <= 1'h1;
    endcase
    repeat (2) @(posedge sys_clk);
    ep_rx_out[i] <= 1'h0;
    ep_rx_setup[i] <= 1'h0;
    ep_tx_ready[i] <= 1'h1;
    ep_tx_done[i] <= 1'h0;
    ep_stall[i] <= 1'h0;
  endtask
endmodule // uhi_ep_model

// ===== verification/uhi_irq_unit_props.sv
// Purpose: port-level properties of the usb hub interrupt unit
// Assumes: clk_en stays high while these are judged
// Notes: global enable is shadowed from bus writes and core pulses
`include "uhi_defs.vh"
module uhi_irq_unit_props #(
  parameter ADDR_W = `UHI_ADDR_W, // address width
  parameter BUSRST_CYC = `UHI_BUSRST_CYC // se0 cycles for a bus reset
) (
  input wire sys_clk, // clock
  input wire rst_b, // reset, active low
  input wire [ADDR_W-1:0] reg_addr, // address
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [7:0] reg_rdata, // read data
  input wire se0_line, // upstream se0
  input wire irq_taken, // core takes irq
  input wire return_from_interrupt, // core returns
  input wire irq_req, // request to core
  input wire usb_logic_reset, // usb-only reset
  input wire cpu_reset_req // processor reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic gie;
  logic [31:0] se0_cnt;
  wire any_rst = usb_logic_reset | cpu_reset_req;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gie <= 1'h0;
      se0_cnt <= 32'h00000000;
    end else begin
      if (irq_taken) gie <= 1'h0;
      else if (return_from_interrupt) gie <= 1'h1;
      else if (reg_wr && reg_addr == `UHI_OFS_PSF) gie <= reg_wdata[7];
      se0_cnt <= !se0_line ? 32'h00000000 : se0_cnt + {31'h0, se0_cnt != 32'hFFFFFFFF};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_status_bit5: assert property (
    $past(reg_rd && (reg_addr == `UHI_OFS_UES || reg_addr == `UHI_OFS_UEE)) |-> !reg_rdata[5])
    else $error("status bit 5 read as one");
  a_ack_reads_zero: assert property (
    $past(reg_rd && reg_addr == `UHI_OFS_UEA) |-> reg_rdata == 8'h00)
    else $error("acknowledge register read nonzero");
  a_susp_upper_zero: assert property (
    $past(reg_rd && (reg_addr == `UHI_OFS_SRS || reg_addr == `UHI_OFS_SRE
      || reg_addr == `UHI_OFS_SRM)) |-> reg_rdata[7:4] == 4'h0)
    else $error("suspend register upper bits nonzero");
  a_gie_gates_irq: assert property (irq_req |-> $past(gie))
    else $error("request raised with global enable low");
  a_taken_drops_irq: assert property (irq_taken |-> ##2 !irq_req)
    else $error("request stayed after interrupt taken");
  a_busrst_apply: assert property (
    se0_line && se0_cnt == BUSRST_CYC + 3 |-> any_rst)
    else $error("long se0 gave no reset");
  a_busrst_cause: assert property (
    any_rst |-> $past(se0_line, 2) && $past(se0_cnt) >= BUSRST_CYC - 2)
    else $error("reset without long se0");
  a_busrst_release: assert property (!se0_line |-> ##[1:2] !any_rst)
    else $error("reset held after se0 ended");
  c_irq: cover property ($rose(irq_req));
  c_taken: cover property (irq_taken ##2 !irq_req);
  c_usb_rst: cover property ($rose(usb_logic_reset));
  c_cpu_rst: cover property ($rose(cpu_reset_req));
endmodule // uhi_irq_unit_props
bind uhi_irq_unit uhi_irq_unit_props #(.ADDR_W(ADDR_W), .BUSRST_CYC(BUSRST_CYC)) u_props (
  .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .se0_line,
  .irq_taken, .return_from_interrupt, .irq_req, .usb_logic_reset, .cpu_reset_req);

// ===== verification/uhi_irq_unit_tb.sv
// Purpose: self-checking bench for the usb hub interrupt unit
// Assumes: clk_en held high, frame period fixed at 100
// Notes: bus reset length cut to 20 cycles to keep the run short
`include "uhi_defs.vh"
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); \
  end \
end
module uhi_irq_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BR = 20;
  logic sys_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, clk_en = 1'h1;
  logic se0_line = 1'h0, external_interrupt_input_1 = 1'h0, global_suspend_seen = 1'h0;
  logic [2:0] pls = 3'h0, port_resume = 3'h0;
  logic [12:0] reg_addr = 13'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] frame_timer = 16'h0000, frame_period = 16'h0064;
  logic [9:0] ep_type = 10'h000;
  wire sof_valid = pls[0], irq_taken = pls[1], return_from_interrupt = pls[2];
  wire [7:0] reg_rdata;
  wire irq_req, usb_logic_reset, cpu_reset_req;
  wire [4:0] ep_rx_out, ep_rx_setup, ep_tx_ready, ep_tx_done, ep_stall;
  int n_mismatch = 0, check_count = 0;
  always #5 sys_clk = ~sys_clk;
  uhi_irq_unit #(.BUSRST_CYC(BR)) DUT (.sys_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sof_valid, .frame_timer, .frame_period, .ep_type,
    .ep_rx_out, .ep_rx_setup, .ep_tx_ready, .ep_tx_done, .ep_stall, .se0_line,
    .external_interrupt_input_1, .port_resume, .global_suspend_seen, .irq_taken,
    .return_from_interrupt, .irq_req, .usb_logic_reset, .cpu_reset_req);
  uhi_ep_model PM (.sys_clk, .ep_rx_out, .ep_rx_setup, .ep_tx_ready, .ep_tx_done, .ep_stall);
  // ------------------------------------------------------------
  // bus and timing helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic chk_rd(input logic [12:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    pls[b] <= 1'h1;
    @(posedge sys_clk);
    pls[b] <= 1'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [12:0] a [4] = '{`UHI_OFS_UEM, `UHI_OFS_UEE, `UHI_OFS_SRE, `UHI_OFS_SRM};
    logic [7:0] e [4] = '{8'hDF, 8'hDF, 8'h0F, 8'h0F};
    chk_rd(`UHI_OFS_PSF, 8'h00);
    chk_rd(`UHI_OFS_UES, 8'h00);
    chk_rd(`UHI_OFS_SRS, 8'h00);
    chk_rd(`UHI_OFS_UEA, 8'h00);
    foreach (a[i]) chk_rd(a[i], 8'h00);
    foreach (a[i]) wr(a[i], 8'hFF);
    wr(13'h0100, 8'hFF);
    foreach (a[i]) chk_rd(a[i], e[i]);
    chk_rd(13'h0100, 8'h00);
    foreach (a[i]) wr(a[i], 8'h00);
  endtask
  task automatic t_frame;
    wr(`UHI_OFS_UEE, 8'hC0);
    wr(`UHI_OFS_PSF, 8'h80);
    pulse(0);
    settle(2);
    `CHK(irq_req, 1'h1)
    chk_rd(`UHI_OFS_UES, 8'h80);
    wr(`UHI_OFS_UEA, 8'h40);
    chk_rd(`UHI_OFS_UES, 8'h80);
    @(posedge sys_clk);
    pls[0] <= 1'h1;
    reg_addr <= `UHI_OFS_UEA;
    reg_wdata <= 8'h80;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    pls[0] <= 1'h0;
    reg_wr <= 1'h0;
    chk_rd(`UHI_OFS_UES, 8'h80);
    wr(`UHI_OFS_UEA, 8'h80);
    chk_rd(`UHI_OFS_UES, 8'h00);
    `CHK(irq_req, 1'h0)
    @(posedge sys_clk);
    frame_timer <= 16'h0059;
    chk_rd(`UHI_OFS_UES, 8'h00);
    @(posedge sys_clk);
    frame_timer <= 16'h005A;
    @(posedge sys_clk);
    frame_timer <= 16'h0000;
    chk_rd(`UHI_OFS_UES, 8'h40);
    wr(`UHI_OFS_UEM, 8'h40);
    settle(2);
    `CHK(irq_req, 1'h0)
    wr(`UHI_OFS_UEA, 8'h40);
    wr(`UHI_OFS_UEM, 8'h00);
  endtask
  task automatic t_endpoints;
    logic [11:0] tab = 12'hB4B;
    int i;
    for (int k = 0; k < 4; k++) begin
      for (int t = 0; t < 3; t++) begin
        i = (k * 3 + t) % 5;
        @(posedge sys_clk);
        ep_type[2*i +: 2] <= 2'(t);
        PM.fire(k, i);
        chk_rd(`UHI_OFS_UES, tab[k*3+t] ? 8'(8'h01 << i) : 8'h00);
        `CHK(irq_req, 1'h0)
        wr(`UHI_OFS_UEA, 8'h1F);
      end
    end
  endtask
  task automatic t_gie;
    wr(`UHI_OFS_PSF, 8'h00);
    wr(`UHI_OFS_UEE, 8'h80);
    pulse(0);
    settle(3);
    `CHK(irq_req, 1'h0)
    wr(`UHI_OFS_PSF, 8'h80);
    settle(2);
    `CHK(irq_req, 1'h1)
    pulse(1);
    settle(1);
    `CHK(irq_req, 1'h0)
    chk_rd(`UHI_OFS_PSF, 8'h00);
    pulse(2);
    settle(2);
    `CHK(irq_req, 1'h1)
    wr(`UHI_OFS_UEA, 8'h80);
    wr(`UHI_OFS_UEE, 8'h00);
  endtask
  task automatic t_suspend;
    wr(`UHI_OFS_SRE, 8'h07);
    wr(`UHI_OFS_SRM, 8'h07);
    @(posedge sys_clk);
    external_interrupt_input_1 <= 1'h1;
    settle(4);
    `CHK(irq_req, 1'h1)
    chk_rd(`UHI_OFS_SRS, 8'h04);
    wr(`UHI_OFS_SRM, 8'h03);
    settle(2);
    `CHK(irq_req, 1'h0)
    @(posedge sys_clk);
    port_resume <= 3'h1;
    settle(3);
    chk_rd(`UHI_OFS_SRS, 8'h04);
    @(posedge sys_clk);
    port_resume <= 3'h5;
    global_suspend_seen <= 1'h1;
    settle(3);
    chk_rd(`UHI_OFS_SRS, 8'h07);
    wr(`UHI_OFS_SRS, 8'h03);
    chk_rd(`UHI_OFS_SRS, 8'h03);
    wr(`UHI_OFS_SRS, 8'h00);
    chk_rd(`UHI_OFS_SRS, 8'h00);
  endtask
  task automatic t_busrst;
    wr(`UHI_OFS_SRE, 8'h08);
    wr(`UHI_OFS_SRM, 8'h08);
    for (int n = 0; n < 2; n++) begin
      @(posedge sys_clk);
      se0_line <= 1'h1;
      settle(BR + 4);
      `CHK(cpu_reset_req, 1'(n))
      if (n == 0) `CHK(usb_logic_reset, 1'h1)
      `CHK(irq_req, 1'(n == 0))
      @(posedge sys_clk);
      se0_line <= 1'h0;
      settle(3);
      `CHK({usb_logic_reset, cpu_reset_req}, 2'h0)
      chk_rd(`UHI_OFS_SRS, n == 0 ? 8'h08 : 8'h00);
      wr(`UHI_OFS_SRS, 8'h00);
      wr(`UHI_OFS_SRE, 8'h00);
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_regs();
    t_frame();
    t_endpoints();
    t_gie();
    t_suspend();
    t_busrst();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end
endmodule // uhi_irq_unit_tb
